// ---- hdl/rps_pkg.sv ----
/*
 * Constants, frame layout and carrier types for the serial parameter access slave.
 * Assumes a byte-wide receiver and transmitter outside, and a 10 MHz system clock.
 */
package rps_pkg;

	localparam logic [7:0]  FN_READ     = 8'h03;
	localparam logic [7:0]  FN_WR16     = 8'h06;
	localparam logic [7:0]  FN_WR32     = 8'h10;
	localparam logic [7:0]  STA_MIN     = 8'h01;
	localparam logic [7:0]  STA_MAX     = 8'hf7;
	localparam logic [15:0] CRC_INIT    = 16'hffff;
	localparam logic [15:0] CRC_POLY    = 16'ha001;
	localparam logic [15:0] CRC_GOOD    = 16'h0000;

	// timing: 11-bit character at 9600 baud
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          CHAR_TIME_NS  = 1145834;
	localparam int          IDLE_HALF_CH  = 7;      // 3.5 characters in half characters
	localparam int          IDLE_W        = 20;

	// request byte positions
	localparam int          BUF_BYTES   = 16;
	localparam logic [3:0]  POS_STA     = 4'h0;
	localparam logic [3:0]  POS_FN      = 4'h1;
	localparam logic [3:0]  POS_AHI     = 4'h2;
	localparam logic [3:0]  POS_ALO     = 4'h3;
	localparam logic [3:0]  POS_QHI     = 4'h4;
	localparam logic [3:0]  POS_QLO     = 4'h5;
	localparam logic [3:0]  POS_BC      = 4'h6;
	localparam logic [3:0]  POS_W32     = 4'h7;
	localparam logic [4:0]  LEN_FIXED   = 5'h08;   // 0x03 and 0x06 requests incl. CRC
	localparam logic [4:0]  LEN_W32_OVH = 5'h09;   // 0x10 request without its data bytes
	localparam logic [7:0]  ECHO_LEN    = 8'h06;
	localparam logic [7:0]  RD_HDR_LEN  = 8'h03;
	localparam logic [7:0]  CRC_LEN     = 8'h02;

	typedef enum logic [2:0] {
		RPS_RX    = 3'b000,
		RPS_CHECK = 3'b001,
		RPS_ACC   = 3'b010,
		RPS_TX    = 3'b011,
		RPS_GAP   = 3'b100
	} rps_state_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} rps_byte_s;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} rps_par_s;

	typedef struct packed {
		rps_state_e                    st;
		logic [IDLE_W-1:0]             idle;
		logic [BUF_BYTES-1:0][7:0]     bytes_b;
		logic [4:0]                    rx_cnt;
		logic                          bad;
		logic [15:0]                   rx_crc;
		logic [15:0]                   tx_crc;
		logic [7:0]                    pos;
		logic [7:0]                    word;
		logic                          have;
		logic [15:0]                   rword;
		rps_par_s                      par;
		rps_byte_s                     tx;
	} rps_regs_s;

endpackage

// ---- hdl/rps_slave.sv ----
/*
 * Serial parameter access slave: frames by line idle time, checks station and CRC,
 * runs parameter reads and writes over a request/acknowledge port and sends the answer.
 * Assumes a receiver that strobes one byte per character and a transmitter with ready.
 */
`timescale 1ns/1ps
`default_nettype none

module rps_slave #(
	parameter int IDLE_CYCLES = (rps_pkg::CHAR_TIME_NS * rps_pkg::IDLE_HALF_CH + 2 * rps_pkg::CLK_PERIOD_NS - 1)
	                            / (2 * rps_pkg::CLK_PERIOD_NS),
	parameter int RD_MAX      = 8,   // most words one read may ask for
	parameter int WR_MAX      = 2    // most words one 0x10 write may carry
) (
	input  wire logic              sys_clk,      // system clock
	input  wire logic              reset,        // synchronous reset, active high
	input  wire logic [7:0]        station_addr, // own station address
	input  wire rps_pkg::rps_byte_s rx,          // received byte strobe
	output var  rps_pkg::rps_byte_s tx,          // byte to send, held until ready
	input  wire logic              tx_ready,     // transmitter takes tx this cycle
	output var  rps_pkg::rps_par_s par,          // parameter access request
	input  wire logic              par_ack,      // access done, one cycle
	input  wire logic [15:0]       par_rdata     // read value, valid with par_ack
);
	import rps_pkg::*;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] x;
		x = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction

	rps_regs_s   r;
	rps_regs_s   n;
	logic        idle_hit;
	logic [7:0]  fn;
	logic [15:0] start;
	logic [15:0] qty;
	logic        rd;
	logic [7:0]  body;
	logic [7:0]  nwords;
	logic        len_ok;
	logic        frame_ok;
	logic [15:0] wr_word;
	logic [3:0]  wi;
	logic [7:0]  tx_byte;

	////////////////////////////////////////////////////////////////////////////
	// request decode

	always_comb begin
		idle_hit = r.idle >= IDLE_W'(IDLE_CYCLES);
		fn       = r.bytes_b[POS_FN];
		start    = {r.bytes_b[POS_AHI], r.bytes_b[POS_ALO]};
		qty      = {r.bytes_b[POS_QHI], r.bytes_b[POS_QLO]};
		rd       = fn == FN_READ;
		body     = rd ? 8'(RD_HDR_LEN + {qty[6:0], 1'b0}) : ECHO_LEN;
		nwords   = (fn == FN_WR32) ? qty[7:0] : 8'h01;
		len_ok   = 1'b0;
		case (fn)
			FN_READ: len_ok = r.rx_cnt == LEN_FIXED && qty != 16'h0000 && qty <= 16'(RD_MAX);
			FN_WR16: len_ok = r.rx_cnt == LEN_FIXED;
			FN_WR32: len_ok = qty != 16'h0000 && qty <= 16'(WR_MAX)
			               && r.bytes_b[POS_BC] == {qty[6:0], 1'b0}
			               && r.rx_cnt == 5'(LEN_W32_OVH + r.bytes_b[POS_BC][4:0]);
			default: len_ok = 1'b0;
		endcase
		// silent discard: no answer for a foreign station or a damaged frame
		frame_ok = !r.bad && r.rx_crc == CRC_GOOD && len_ok
		        && station_addr >= STA_MIN && station_addr <= STA_MAX
		        && r.bytes_b[POS_STA] == station_addr;
		wi       = 4'(POS_W32 + {r.word[2:0], 1'b0});
		wr_word  = (fn == FN_WR32) ? {r.bytes_b[wi], r.bytes_b[4'(wi + 4'h1)]}
		                           : {r.bytes_b[POS_QHI], r.bytes_b[POS_QLO]};
		if (r.pos == body) begin
			tx_byte = r.tx_crc[7:0];
		end else if (r.pos > body) begin
			tx_byte = r.tx_crc[15:8];
		end else if (!rd || r.pos < 8'h02) begin
			tx_byte = r.bytes_b[r.pos[3:0]];
		end else if (r.pos == 8'h02) begin
			tx_byte = {qty[6:0], 1'b0};
		end else begin
			tx_byte = r.pos[0] ? r.rword[15:8] : r.rword[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		n = r;
		n.idle = rx.valid ? '0 : (idle_hit ? r.idle : r.idle + 1'b1);
		case (r.st)
			RPS_RX: begin
				if (rx.valid) begin
					// a first byte not preceded by a full idle gap spoils the frame
					if ((r.rx_cnt == 5'h00 && !idle_hit) || r.rx_cnt == 5'(BUF_BYTES)) begin
						n.bad = 1'b1;
					end else begin
						n.bytes_b[r.rx_cnt[3:0]] = rx.data;
						n.rx_cnt = r.rx_cnt + 5'h01;
					end
					n.rx_crc = crc_byte(r.rx_crc, rx.data);
				end else if (idle_hit && r.rx_cnt != 5'h00) begin
					n.st = RPS_CHECK;
				end else if (idle_hit) begin
					n.bad    = 1'b0;
					n.rx_crc = CRC_INIT;
				end
			end
			RPS_CHECK: begin
				n.rx_cnt = '0;
				n.rx_crc = CRC_INIT;
				n.bad    = 1'b0;
				n.word   = '0;
				n.have   = 1'b0;
				n.pos    = '0;
				n.tx_crc = CRC_INIT;
				n.st     = !frame_ok ? RPS_RX : (rd ? RPS_TX : RPS_ACC);
			end
			RPS_ACC: begin
				if (!r.par.req) begin
					n.par.req   = 1'b1;
					n.par.we    = !rd;
					n.par.addr  = start + {8'h00, r.word};
					n.par.wdata = wr_word;
				end else if (par_ack) begin
					n.par.req = 1'b0;
					n.word    = r.word + 8'h01;
					if (rd) begin
						n.rword = par_rdata;
						n.have  = 1'b1;
						n.st    = RPS_TX;
					end else if (r.word + 8'h01 == nwords) begin
						n.st = RPS_TX;
					end
				end
			end
			RPS_TX: begin
				if (r.tx.valid) begin
					if (tx_ready) begin
						n.tx.valid = 1'b0;
						n.pos      = r.pos + 8'h01;
						if (r.pos < body) begin
							n.tx_crc = crc_byte(r.tx_crc, r.tx.data);
						end
						if (rd && r.pos > RD_HDR_LEN && r.pos < body && !r.pos[0]) begin
							n.have = 1'b0;
						end
					end
				end else if (r.pos == 8'(body + CRC_LEN)) begin
					// gap is timed from the last hand-off, so it includes the last character
					n.idle = '0;
					n.st   = RPS_GAP;
				end else if (rd && r.pos >= RD_HDR_LEN && r.pos < body && !r.have) begin
					n.st = RPS_ACC;
				end else begin
					n.tx.valid = 1'b1;
					n.tx.data  = tx_byte;
				end
			end
			RPS_GAP: begin
				if (idle_hit) begin
					n.st = RPS_RX;
				end
			end
			default: n.st = RPS_RX;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			r        <= '0;
			r.st     <= RPS_RX;
			r.rx_crc <= CRC_INIT;
			r.tx_crc <= CRC_INIT;
		end else begin
			r <= n;
		end
	end

	assign tx  = r.tx;
	assign par = r.par;

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_pending;
		r.par.req && !par_ack;
	endsequence

	a_req_held: assert property (@(posedge sys_clk) disable iff (reset)
		s_pending |=> r.par.req && $stable(r.par.addr))
		else $error("access request dropped before acknowledge");
	a_rd_cmd: assert property (@(posedge sys_clk) disable iff (reset)
		r.par.req && !r.par.we |-> fn == FN_READ)
		else $error("read access without read command");
	a_wr_cmd: assert property (@(posedge sys_clk) disable iff (reset)
		r.par.req && r.par.we |-> fn == FN_WR16 || fn == FN_WR32)
		else $error("write access without write command");
	a_par_addr: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(r.par.req) |-> r.par.addr == start + {8'h00, r.word})
		else $error("access address not start plus word index");
	a_sta_first: assert property (@(posedge sys_clk) disable iff (reset)
		r.tx.valid && r.pos == 8'h00 |-> r.tx.data == station_addr)
		else $error("answer does not open with station address");
	a_byte_count: assert property (@(posedge sys_clk) disable iff (reset)
		r.tx.valid && rd && r.pos == 8'h02 |-> r.tx.data == {qty[6:0], 1'b0})
		else $error("byte count not twice the word count");
	a_data_order: assert property (@(posedge sys_clk) disable iff (reset)
		r.tx.valid && rd && r.pos >= RD_HDR_LEN && r.pos < body |->
		r.tx.data == (r.pos[0] ? r.rword[15:8] : r.rword[7:0]))
		else $error("read data out of order");
	a_echo: assert property (@(posedge sys_clk) disable iff (reset)
		r.tx.valid && !rd && r.pos < ECHO_LEN |-> r.tx.data == r.bytes_b[r.pos[3:0]])
		else $error("write answer does not echo request");
	a_crc_low: assert property (@(posedge sys_clk) disable iff (reset)
		r.tx.valid && r.pos == body |-> r.tx.data == r.tx_crc[7:0])
		else $error("check low byte wrong");
	a_discard: assert property (@(posedge sys_clk) disable iff (reset)
		r.st == RPS_CHECK ##1 r.st != RPS_RX |->
		$past(r.rx_crc) == CRC_GOOD && $past(r.bytes_b[POS_STA]) == station_addr)
		else $error("answered a foreign or damaged frame");
	a_idle_end: assert property (@(posedge sys_clk) disable iff (reset)
		r.st == RPS_RX ##1 r.st == RPS_CHECK |-> $past(idle_hit))
		else $error("frame closed before idle time");

endmodule

`default_nettype wire

// ---- dv/rps_host_model.sv ----
/*
 * Host master model: sends request frames byte by byte and paces the answer stream.
 * Assumes the bench calls send only after the previous answer and its idle gap.
 */
`timescale 1ns/1ps
`default_nettype none

module rps_host_model (
	input  wire logic               sys_clk,  // system clock
	input  wire logic               slow,     // stall the answer stream at random
	output var  rps_pkg::rps_byte_s rx,       // bytes towards the slave
	output var  logic               tx_ready  // takes the offered answer byte
);
	import rps_pkg::*;
	int seed = 29506;

	initial begin
		rx = '0;
		tx_ready = 1'b0;
	end

	// random stalls show whether answer bytes really stand until taken
	always @(posedge sys_clk) begin
		tx_ready <= !slow || $random(seed) > 0;
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
			end
		end
		return c;
	endfunction

	// bytes keep a short gap so the frame never splits; the idle before is the caller's
	task automatic send(input logic [7:0] b[$], input logic no_crc, input logic bad_crc);
		logic [15:0] c;
		c = crc16(b) ^ {15'h0000, bad_crc};
		if (!no_crc) begin
			b.push_back(c[7:0]);
			b.push_back(c[15:8]);
		end
		foreach (b[i]) begin
			@(posedge sys_clk);
			rx <= '{valid: 1'b1, data: b[i]};
			@(posedge sys_clk);
			rx <= '{valid: 1'b0, data: ~b[i]};
			repeat (1 + ($random(seed) & 3)) @(posedge sys_clk);
		end
	endtask
endmodule

`default_nettype wire

// ---- dv/rps_slave_bench.sv ----
/*
 * Self-checking bench for the parameter access slave: host model on the byte link,
 * a parameter store on the access port. Assumes a short idle count for simulation.
 */
`timescale 1ns/1ps
`default_nettype none

module rps_slave_bench;
	import rps_pkg::*;
	localparam int IDLE = 40;
	localparam int NMAX = 8;
	logic        sys_clk      = 1'b0;
	logic        reset        = 1'b1;
	logic [7:0]  station_addr = 8'h01;
	logic        slow         = 1'b0;
	logic        par_ack      = 1'b0;
	logic [15:0] par_rdata    = 16'h0000;
	logic        tx_ready;
	rps_byte_s   rx;
	rps_byte_s   tx;
	rps_par_s    par;
	logic [7:0]  want;
	logic        acc_any      = 1'b0;
	logic        acc_we       = 1'b0;
	logic [7:0]  exp_q[$];
	logic [15:0] dev_mem[logic [15:0]];
	logic [15:0] ref_mem[logic [15:0]];
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles     = 0;
	int          hold       = 0;
	int          seed       = 29506;

	always #50 sys_clk = ~sys_clk;

	rps_slave #(.IDLE_CYCLES(IDLE), .RD_MAX(NMAX), .WR_MAX(2)) i_dut (
		.sys_clk(sys_clk), .reset(reset), .station_addr(station_addr), .rx(rx), .tx(tx),
		.tx_ready(tx_ready), .par(par), .par_ack(par_ack), .par_rdata(par_rdata));
	rps_host_model u_host (.sys_clk(sys_clk), .slow(slow), .rx(rx), .tx_ready(tx_ready));

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] pval(input logic [15:0] a);
		return ref_mem.exists(a) ? ref_mem[a] : a ^ 16'h3c5a;
	endfunction

	// store answers with random latency; hold skips the edge where req still stands
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		par_ack <= 1'b0;
		if (hold != 0) begin
			hold <= hold - 1;
		end else if (par.req === 1'b1 && $random(seed) > 0) begin
			par_ack <= 1'b1;
			par_rdata <= dev_mem.exists(par.addr) ? dev_mem[par.addr] : par.addr ^ 16'h3c5a;
			num_checks++;
			if (acc_any !== 1'b1 || par.we !== acc_we) begin
				mismatches++;
				$display("wrong value at %0t: got %h expected %h", $time, {acc_any, par.we}, {1'b1, acc_we});
			end
			if (par.we === 1'b1) dev_mem[par.addr] = par.wdata;
			hold <= 2;
		end
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end

	// an unexpected byte is compared with its own inverse so it always counts
	always @(posedge sys_clk) begin
		if (!reset && tx.valid === 1'b1 && tx_ready === 1'b1) begin
			want = (exp_q.size() != 0) ? exp_q.pop_front() : ~tx.data;
			num_checks++;
			if (tx.data !== want) begin
				mismatches++;
				$display("wrong value at %0t: got %h expected %h", $time, tx.data, want);
			end
		end
	end

	task automatic xact(input logic [7:0] rq[$], input logic [7:0] rs[$], input logic [1:0] mode);
		logic [15:0] c;
		c = u_host.crc16(rs);
		if (rs.size() != 0) exp_q = {exp_q, rs, c[7:0], c[15:8]};
		// only a frame that earns an answer may reach the store, and only in its own direction
		acc_any = rs.size() != 0;
		acc_we  = rq[1] != FN_READ;
		u_host.send(rq, mode[0], mode[1]);
		for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge sys_clk);
		repeat (IDLE + 8) @(posedge sys_clk);
	endtask

	task automatic test_done();
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0]  s;
		logic [7:0]  rq[$];
		logic [7:0]  rs[$];
		logic [15:0] a;
		logic [15:0] v;
		logic [15:0] w;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (IDLE + 8) @(posedge sys_clk);
		for (int j = 0; j < 3; j++) begin
			s = (j == 0) ? STA_MIN : (j == 1) ? STA_MAX : 8'(2 + {$random(seed)} % 245);
			station_addr <= s;
			slow <= j[0];
			a = 16'($random(seed));
			v = 16'($random(seed));
			ref_mem[a] = v;
			rq = {s, FN_WR16, a[15:8], a[7:0], v[15:8], v[7:0]};
			xact(rq, rq, 2'b00);
			rs.delete();
			rq = {s + 8'h01, FN_WR16, a[15:8], a[7:0], ~v[15:8], v[7:0]};
			xact(rq, rs, 2'b00);
			rq[0] = s;
			xact(rq, rs, 2'b10);
			rq = {s, FN_WR16, a[15:8], a[7:0]};
			xact(rq, rs, 2'b01);
			rq = {~v[15:8], v[7:0]};
			xact(rq, rs, 2'b00);
			rq = {s, FN_READ, a[15:8], a[7:0], 8'h00, 8'h01};
			rs = {s, FN_READ, 8'h02, v[15:8], v[7:0]};
			xact(rq, rs, 2'b00);
		end
		v = 16'($random(seed));
		w = 16'($random(seed));
		ref_mem[16'h0507] = v;
		ref_mem[16'h0508] = w;
		rq = {s, FN_WR32, 8'h05, 8'h07, 8'h00, 8'h02, 8'h04, v[15:8], v[7:0], w[15:8], w[7:0]};
		rs = rq[0:5];
		xact(rq, rs, 2'b00);
		rs.delete();
		rq[6] = 8'h03;
		rq[7] = ~v[15:8];
		xact(rq, rs, 2'b00);
		rq = {s, FN_READ, 8'h05, 8'h07, 8'h00, 8'h02};
		rs = {s, FN_READ, 8'h04, v[15:8], v[7:0], w[15:8], w[7:0]};
		xact(rq, rs, 2'b00);
		a = 16'($random(seed));
		rq = {s, FN_READ, a[15:8], a[7:0], 8'h00, 8'(NMAX)};
		rs = {s, FN_READ, 8'(2 * NMAX)};
		for (int k = 0; k < NMAX; k++) begin
			v = pval(a + 16'(k));
			rs.push_back(v[15:8]);
			rs.push_back(v[7:0]);
		end
		xact(rq, rs, 2'b00);
		rs.delete();
		rq[5] = 8'h00;
		xact(rq, rs, 2'b00);
		rq[5] = 8'(NMAX + 1);
		xact(rq, rs, 2'b00);
		rq[1] = 8'h04;
		rq[5] = 8'h01;
		xact(rq, rs, 2'b00);
		if (exp_q.size() != 0) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, 8'h00, exp_q[0]);
		end
		test_done();
	end
endmodule

`default_nettype wire
